// ---- logic/iod_top.sv ----
// Module: host I/O decode, peripheral selects and key strobe port
`timescale 1ns/1ps
`default_nettype none
module iod_top (
   // Clock and reset
   input  wire logic                        clk,
   input  wire logic                        sys_rst,
   // Host I/O bus
   input  wire logic                        io_request_n,
   input  wire logic [iod_pkg::ADDR_W-1:0]  io_addr,
   // Peripheral selects
   output var  logic                        serial_ctrl_select_n,
   output var  logic                        peripheral_enable,
   // Secondary processor
   input  wire logic                        aux_cpu_mem_access,
   output var  logic                        aux_cpu_mem_select,
   // Key strobe control from the port controller
   input  wire logic [iod_pkg::KS_W-1:0]    ks_ctrl_data,
   input  wire logic [iod_pkg::KS_W-1:0]    ks_ctrl_dir,
   output var  logic [iod_pkg::KS_W-1:0]    ks_ctrl_read,
   // Key strobe pins
   input  wire logic [iod_pkg::KS_W-1:0]    key_strobe_lines_in,
   output var  logic [iod_pkg::KS_W-1:0]    key_strobe_lines_out,
   output var  logic [iod_pkg::KS_W-1:0]    key_strobe_lines_oe,
   output var  logic [iod_pkg::KS_W-1:0]    key_strobe_lines_pullup
);
   import iod_pkg::*;

   // ************************************************
   // Declarations
   // ************************************************
   iod_dec_if          dec_bus ();           // Decoder hand-off
   logic               ser_sel_n_ff;         // Serial select flop
   logic               nxt_ser_sel_n;        // Its next value
   logic               lcd_hit_ff;           // Display hit, rising-edge stage
   logic               nxt_lcd_hit;          // Its next value
   logic               per_en_ff;            // Enable, falling-edge stage
   logic               nxt_per_en;           // Its next value
   logic               aux_sel_ff;           // Aux memory select flop
   logic               nxt_aux_sel;          // Its next value
   logic [KS_W-1:0]    ks_out_ff;            // Line drive level
   logic [KS_W-1:0]    nxt_ks_out;           // Its next value
   logic [KS_W-1:0]    ks_oe_ff;             // Line drive enable
   logic [KS_W-1:0]    nxt_ks_oe;            // Its next value
   logic [KS_W-1:0]    ks_pu_ff;             // Pull-up enable
   logic [KS_W-1:0]    nxt_ks_pu;            // Its next value
   logic [KS_W-1:0]    ks_rd_ff;             // Read-back of line levels
   logic [KS_W-1:0]    nxt_ks_rd;            // Its next value

   // ************************************************
   // Address decode
   // ************************************************
   assign dec_bus.addr   = io_addr;
   assign dec_bus.io_req = !io_request_n;

   iod_decode u_decode (
      .dec (dec_bus.decoder)
   );

   // ************************************************
   // Select and enable, next values
   // ************************************************
   // Hits already carry the request, so an idle bus falls to the idle levels
   always_comb begin
      nxt_ser_sel_n = !dec_bus.ser_hit;
      nxt_lcd_hit   = dec_bus.lcd_hit;
      nxt_per_en    = lcd_hit_ff;
      nxt_aux_sel   = aux_cpu_mem_access;
   end

   // Rising-edge stage for select, hit and aux select
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ser_sel_n_ff <= RST_SER_SEL_N;
         lcd_hit_ff   <= RST_PER_EN;
         aux_sel_ff   <= RST_AUX_SEL;
      end else begin
         ser_sel_n_ff <= nxt_ser_sel_n;
         lcd_hit_ff   <= nxt_lcd_hit;
         aux_sel_ff   <= nxt_aux_sel;
      end
   end

   // Falling-edge stage: the only way to get half a period on one clock,
   // at the cost of a half-cycle timing path from lcd_hit_ff
   always_ff @(negedge clk) begin
      if (sys_rst) begin
         per_en_ff <= RST_PER_EN;
      end else begin
         per_en_ff <= nxt_per_en;
      end
   end

   // ************************************************
   // Key strobe port
   // ************************************************
   // Direction and level are copied per line; the controller is trusted
   // to raise a low line before turning it round to input
   always_comb begin
      nxt_ks_oe  = ks_ctrl_dir;
      nxt_ks_out = ks_ctrl_data;
      nxt_ks_pu  = ~ks_ctrl_dir;
      // Read-back sees the resolved pin level
      nxt_ks_rd  = key_strobe_lines_in;
   end

   // Key strobe registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ks_oe_ff  <= RST_KS_OE;
         ks_out_ff <= RST_KS_OUT;
         ks_pu_ff  <= ~RST_KS_OE;
         ks_rd_ff  <= RST_KS_OUT;
      end else begin
         ks_oe_ff  <= nxt_ks_oe;
         ks_out_ff <= nxt_ks_out;
         ks_pu_ff  <= nxt_ks_pu;
         ks_rd_ff  <= nxt_ks_rd;
      end
   end

   // ************************************************
   // Outputs
   // ************************************************
   assign serial_ctrl_select_n    = ser_sel_n_ff;
   assign peripheral_enable       = per_en_ff;
   assign aux_cpu_mem_select      = aux_sel_ff;
   assign key_strobe_lines_out    = ks_out_ff;
   assign key_strobe_lines_oe     = ks_oe_ff;
   assign key_strobe_lines_pullup = ks_pu_ff;
   assign ks_ctrl_read            = ks_rd_ff;

   // ************************************************
   // Assertions
   // ************************************************
   // Host cycle that lands in the serial window
   sequence ser_access_s;
      !io_request_n && in_range(io_addr, SER_LO, SER_HI);
   endsequence

   // Host cycle that lands in the display window
   sequence lcd_access_s;
      !io_request_n && in_range(io_addr, LCD_LO, LCD_HI);
   endsequence

   serial_select_a: assert property (
      @(posedge clk) disable iff (sys_rst)
      ser_access_s |=> !serial_ctrl_select_n)
      else $error("serial select not low after serial access");

   // Any other cycle must leave the serial select released
   serial_only_a: assert property (
      @(posedge clk) disable iff (sys_rst)
      !(!io_request_n && in_range(io_addr, SER_LO, SER_HI)) |=> serial_ctrl_select_n)
      else $error("serial select low without a serial access");

   // Enable is set at the falling edge, so the next rising edge sees it high
   periph_enable_a: assert property (
      @(posedge clk) disable iff (sys_rst)
      lcd_access_s |=> peripheral_enable)
      else $error("peripheral enable not high after display access");

   // Checked on the falling edge, where the half-cycle stage launches
   half_delay_a: assert property (
      @(negedge clk) disable iff (sys_rst)
      $rose(lcd_hit_ff) |-> !peripheral_enable ##1 peripheral_enable)
      else $error("enable did not lag the hit by half a clock");

   // One rising edge of latency, nothing more
   aux_select_a: assert property (
      @(posedge clk) disable iff (sys_rst)
      ##1 aux_cpu_mem_select == $past(aux_cpu_mem_access))
      else $error("aux memory select does not follow access");

   // Read-back shows the pin level one edge later
   ks_read_a: assert property (
      @(posedge clk) disable iff (sys_rst)
      ##1 ks_ctrl_read == $past(key_strobe_lines_in))
      else $error("key strobe read-back does not follow the pins");

   ks_drive_a: assert property (
      @(posedge clk) disable iff (sys_rst)
      ##1 (key_strobe_lines_oe == $past(ks_ctrl_dir))
          && (key_strobe_lines_out == $past(ks_ctrl_data)))
      else $error("key strobe direction or level not taken");

   // Pull-up follows the requested direction, not just the enable flop
   ks_pullup_a: assert property (
      @(posedge clk) disable iff (sys_rst)
      ##1 (key_strobe_lines_pullup == ~$past(ks_ctrl_dir)))
      else $error("pull-up not set on exactly the input lines");

   // Quiet bus for two edges leaves both selects idle
   idle_levels_a: assert property (
      @(posedge clk) disable iff (sys_rst)
      io_request_n [*2] |=> serial_ctrl_select_n && !peripheral_enable)
      else $error("select or enable active with no request");

   // Enable seen high at an edge needs a display access one edge before
   enable_only_lcd_a: assert property (
      @(posedge clk) disable iff (sys_rst)
      peripheral_enable |-> $past(!io_request_n && in_range(io_addr, LCD_LO, LCD_HI)))
      else $error("enable high without a display access");

endmodule // iod_top
`default_nettype wire

// ---- logic/iod_pkg.sv ----
// Package: port ranges, widths, reset values and decode helper for the I/O glue
package iod_pkg;

   // ************************************************
   // Widths
   // ************************************************
   localparam int ADDR_W = 8;   // Host I/O port address width
   localparam int KS_W   = 8;   // Key strobe line count

   // ************************************************
   // Port address ranges
   // ************************************************
   localparam logic [ADDR_W-1:0] SER_LO = 8'h20;  // Serial controller range start
   localparam logic [ADDR_W-1:0] SER_HI = 8'h27;  // Serial controller range end
   localparam logic [ADDR_W-1:0] LCD_LO = 8'h40;  // Display driver range start
   localparam logic [ADDR_W-1:0] LCD_HI = 8'h5F;  // Display driver range end

   // ************************************************
   // Reset values
   // ************************************************
   localparam logic            RST_SER_SEL_N = 1'h1;  // Select idles high
   localparam logic            RST_PER_EN    = 1'h0;  // Enable idles low
   localparam logic            RST_AUX_SEL   = 1'h0;  // Memory select idles low
   localparam logic [KS_W-1:0] RST_KS_OUT    = 8'hFF; // Lines idle high
   localparam logic [KS_W-1:0] RST_KS_OE     = 8'h00; // All lines start as inputs

   // Inclusive range check, used for both windows
   function automatic logic in_range(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] lo,
                                     input logic [ADDR_W-1:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

endpackage

// ---- logic/iod_dec_if.sv ----
// Interface: address decoder hand-off between decoder and top
`timescale 1ns/1ps
`default_nettype none
interface iod_dec_if;
   import iod_pkg::*;
   logic [ADDR_W-1:0] addr;     // Host port address
   logic              io_req;   // Host I/O cycle active (true high)
   logic              ser_hit;  // Serial range hit
   logic              lcd_hit;  // Display range hit

   modport decoder (input addr, input io_req, output ser_hit, output lcd_hit);
   modport user    (output addr, output io_req, input ser_hit, input lcd_hit);
endinterface
`default_nettype wire

// ---- logic/iod_decode.sv ----
// Module: combinational port address decoder
`timescale 1ns/1ps
`default_nettype none
module iod_decode (
   // Decode hand-off
   iod_dec_if.decoder dec
);
   import iod_pkg::*;

   // ************************************************
   // Range decode
   // ************************************************
   // Hits are qualified by the I/O cycle so memory cycles never select
   always_comb begin
      dec.ser_hit = dec.io_req && in_range(dec.addr, SER_LO, SER_HI);
      dec.lcd_hit = dec.io_req && in_range(dec.addr, LCD_LO, LCD_HI);
   end
endmodule // iod_decode
`default_nettype wire

// ---- testbench/iod_key_model.sv ----
// Key matrix and wire model standing on the far side of the key strobe lines
`timescale 1ns/1ps
`default_nettype none
module iod_key_model (
   // Clock
   input  wire logic                     clk,
   // Drive from the design
   input  wire logic [iod_pkg::KS_W-1:0] drv_out,
   input  wire logic [iod_pkg::KS_W-1:0] drv_oe,
   input  wire logic [iod_pkg::KS_W-1:0] pu_en,
   // Pressed keys pull their line low unless the design drives it
   input  wire logic [iod_pkg::KS_W-1:0] key_low,
   // Resolved wire level
   output var  logic [iod_pkg::KS_W-1:0] lines
);
   import iod_pkg::*;
   logic [KS_W-1:0] last_ff;  // Last level; a floating line shows its inverse, never a kind guess
   always_comb begin
      for (int i = 0; i < KS_W; i++) begin
         lines[i] = drv_oe[i] ? drv_out[i] : key_low[i] ? 1'b0 : pu_en[i] ? 1'b1 : ~last_ff[i];
      end
   end
   // Remember the level for the float case
   always_ff @(posedge clk) begin
      last_ff <= lines;
   end
endmodule // iod_key_model
`default_nettype wire

// ---- testbench/iod_top_tb_top.sv ----
// Self-checking bench for the host I/O decode and key strobe block
`timescale 1ns/1ps
`default_nettype none
module iod_top_tb_top;
   import iod_pkg::*;
   // ************************************************
   // Stimulus and observed signals
   // ************************************************
   logic            clk = 1'b0;
   logic            sys_rst = 1'b1;
   logic            io_request_n = 1'b1;
   logic [ADDR_W-1:0] io_addr = 8'h00;
   logic            aux_acc = 1'b0;     // Secondary cpu access
   logic [KS_W-1:0] ks_data = 8'hFF;    // Controller drive level
   logic [KS_W-1:0] ks_dir = 8'h00;     // Controller direction
   logic [KS_W-1:0] key_low = 8'h00;    // Pressed keys
   logic            sel_n, en, aux_sel;
   logic [KS_W-1:0] ks_read, ks_out, ks_oe, ks_pu, ks_pins;
   int              n_mismatch = 0;
   int              comparisons = 0;
   int              cycles = 0;
   // 10 MHz clock
   always #50 clk = ~clk;
   iod_top uut (.clk(clk), .sys_rst(sys_rst), .io_request_n(io_request_n), .io_addr(io_addr),
      .serial_ctrl_select_n(sel_n), .peripheral_enable(en), .aux_cpu_mem_access(aux_acc),
      .aux_cpu_mem_select(aux_sel), .ks_ctrl_data(ks_data), .ks_ctrl_dir(ks_dir),
      .ks_ctrl_read(ks_read), .key_strobe_lines_in(ks_pins), .key_strobe_lines_out(ks_out),
      .key_strobe_lines_oe(ks_oe), .key_strobe_lines_pullup(ks_pu));
   iod_key_model far (.clk(clk), .drv_out(ks_out), .drv_oe(ks_oe), .pu_en(ks_pu),
      .key_low(key_low), .lines(ks_pins));
   // Compare and count
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Report and end
   task automatic test_done;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Hang guard, well above the fifty or so cycles needed
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         n_mismatch++;
         test_done();
      end
   end
   // Serial window edges, one request every other cycle
   task automatic test_serial;
      logic [7:0] a [5] = '{8'h1F, 8'h20, 8'h27, 8'h28, 8'h45};
      foreach (a[i]) begin
         @(negedge clk) io_request_n = 1'b0;
         io_addr = a[i];
         @(posedge clk) #1;
         check("sel_n", sel_n, (a[i] >= 8'h20 && a[i] <= 8'h27) ? 8'h00 : 8'h01);
         @(negedge clk) io_request_n = 1'b1;
         @(posedge clk) #1;
         check("sel_n idle", sel_n, 8'h01);
      end
   endtask
   // Display window edges; enable lags by half a clock
   task automatic test_display;
      logic [7:0] a [5] = '{8'h3F, 8'h40, 8'h5F, 8'h60, 8'h22};
      foreach (a[i]) begin
         @(negedge clk) io_request_n = 1'b0;
         io_addr = a[i];
         @(posedge clk) #1;
         check("en early", en, 8'h00);
         @(negedge clk) #1;
         check("en half", en, (a[i] >= 8'h40 && a[i] <= 8'h5F) ? 8'h01 : 8'h00);
         @(negedge clk) io_request_n = 1'b1;
         #1 check("en", en, (a[i] >= 8'h40 && a[i] <= 8'h5F) ? 8'h01 : 8'h00);
         repeat (2) @(posedge clk);
         #1 check("en idle", en, 8'h00);
      end
      // An in-range address without a request changes nothing
      @(negedge clk) io_addr = 8'h45;
      repeat (2) @(posedge clk);
      #1 check("en no req", {sel_n, en}, 8'h02);
   endtask
   // Aux memory select follows the access
   task automatic test_aux;
      @(negedge clk) aux_acc = 1'b1;
      @(posedge clk) #1 check("aux on", aux_sel, 8'h01);
      @(negedge clk) aux_acc = 1'b0;
      @(posedge clk) #1 check("aux off", aux_sel, 8'h00);
   endtask
   // One controller step on the strobe port
   task automatic ks_step(input logic [7:0] dir, input logic [7:0] dat, input logic [7:0] keys,
                          input logic [7:0] exp_rd);
      @(negedge clk) ks_dir = dir;
      ks_data = dat;
      key_low = keys;
      @(posedge clk) #1 check("ks oe", ks_oe, dir);
      check("ks pullup", ks_pu, ~dir);
      check("ks out", ks_out, dat);
      @(posedge clk) #1 check("ks read", ks_read, exp_rd);
   endtask
   // Per-line direction, pull-up and a strobe release
   task automatic test_keys;
      ks_step(8'hFF, 8'hA5, 8'h00, 8'hA5);
      ks_step(8'h01, 8'h00, 8'h00, 8'hFE);
      ks_step(8'h01, 8'h00, 8'h80, 8'h7E);
      // raise the low line before making it input
      ks_step(8'h01, 8'h01, 8'h00, 8'hFF);
      ks_step(8'h00, 8'h01, 8'h00, 8'hFF);
   endtask
   // Main sequence: 3 cycles of reset, then each scenario
   initial begin
      repeat (3) @(negedge clk);
      check("rst sel_n en aux", {sel_n, en, aux_sel}, 8'h04);
      check("rst pins", {ks_out & ks_pu & ks_read}, 8'hFF);
      check("rst oe", ks_oe, 8'h00);
      sys_rst = 1'b0;
      test_serial();
      test_display();
      test_aux();
      test_keys();
      test_done();
   end
endmodule // iod_top_tb_top
`default_nettype wire
